// ### rtl/rail_override_defs.vh
// Behaviour
// - Bit 6 low kills switch rail B
// - Bit 5 low kills switch rail A
// - Bit 4 low kills termination regulator
// - Bit 3 forces termination regulator on
// - Bit 1 forces switch rail B on
// - Bit 0 enables linear A3 regardless of pin
// - Override resets 0x70; bits 7,2 plain storage
// - Output control bit 5 low pulls pin low
// - Fault mask bit per rail, fixed order
// - Mask set stops that rail's fault shutdown
// - Fault mask resets to 0xC0
`ifndef RAIL_OVERRIDE_DEFS_VH
`define RAIL_OVERRIDE_DEFS_VH
// Register indices; one aligned word each, so byte address is four times the index
`define IDX_OVERRIDE        8'h9f
`define IDX_GPO             8'ha1
`define IDX_FAULT_MASK      8'ha2
`define IDX_UNMAPPED        8'ha0
`define IDX_IRQ_STATUS      8'hb0
`define IDX_IRQ_MASK        8'hb1
`define IDX_RAIL_STATE      8'hb2
`define ADDR_OVERRIDE       12'h27c
`define ADDR_GPO            12'h284
`define ADDR_FAULT_MASK     12'h288
`define ADDR_UNMAPPED       12'h280
`define ADDR_IRQ_STATUS     12'h2c0
`define ADDR_IRQ_MASK       12'h2c4
`define ADDR_RAIL_STATE     12'h2c8
`define RST_OVERRIDE        8'h70
`define RST_GPO             8'h20
`define RST_FAULT_MASK      8'hc0
`define RST_IRQ_MASK        8'h00
`define BIT_SWB_KILL_N      6
`define BIT_SWA_KILL_N      5
`define BIT_TERM_KILL_N     4
`define BIT_TERM_FORCE      3
`define BIT_SWB_FORCE       1
`define BIT_LA3_FORCE       0
`define BIT_GPO_LEVEL       5
`endif

// ### rtl/reset_sync.v
`timescale 1ns/1ps
module reset_sync (
    input  wire clk,
    input  wire rst_n,
    output wire rst_sync_n
);
    reg [1:0] sync_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_reg <= 2'b00;
        end else begin
            sync_reg <= {sync_reg[0], 1'b1};
        end
    end
    assign rst_sync_n = sync_reg[1];
endmodule // reset_sync

// ### rtl/rail_override_fault_mask_regs.v
`timescale 1ns/1ps
`include "rail_override_defs.vh"
module rail_override_fault_mask_regs #(
    parameter [7:0] OVERRIDE_RESET = `RST_OVERRIDE
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        seq_switch_b_en,
    input  wire        seq_switch_a_en,
    input  wire        seq_term_en,
    input  wire        shared_linear_enable_pin,
    input  wire [7:0]  rail_fault,
    output reg         switch_rail_b_en,
    output reg         switch_rail_a_en,
    output reg         termination_reg_en,
    output reg         linear_reg_a3_en,
    output reg         shutdown_req,
    output reg         open_drain_out_o,
    output reg         open_drain_out_oe,
    output reg         irq
);
    wire       rst_s_n;
    reg  [7:0] override_reg;
    reg  [7:0] gpo_reg;
    reg  [7:0] fault_mask_reg;
    reg  [7:0] irq_status_reg;
    reg  [7:0] irq_mask_reg;
    reg  [31:0] rdata_next;
    reg        addr_ok;
    wire       wr_fire;
    wire       rd_fire;
    wire [7:0] fault_hit;
    wire       switch_rail_b_kill_n;
    wire       switch_rail_a_kill_n;
    wire       termination_reg_kill_n;
    wire       termination_reg_force_on;
    wire       switch_rail_b_force_on;
    wire       linear_reg_a3_force_on;
    wire       open_drain_out_level;
    wire       en_b;
    wire       en_a;
    wire       en_t;
    wire       en_l;
    wire [7:0] clr_bits;

    reset_sync u_reset_sync (
        .clk        (clk),
        .rst_n      (rst_n),
        .rst_sync_n (rst_s_n)
    );

    // One wait state; a write lands only on the edge where pready is seen high
    assign wr_fire = psel & penable & pwrite & pready;
    assign rd_fire = psel & penable & ~pwrite & ~pready;

    always @* begin
        addr_ok = 1'b1;
        rdata_next = 32'h0000_0000;
        case (paddr)
            `ADDR_OVERRIDE:   rdata_next = {24'h00_0000, override_reg};
            `ADDR_GPO:        rdata_next = {24'h00_0000, gpo_reg};
            `ADDR_FAULT_MASK: rdata_next = {24'h00_0000, fault_mask_reg};
            `ADDR_IRQ_STATUS: rdata_next = {24'h00_0000, irq_status_reg};
            `ADDR_IRQ_MASK:   rdata_next = {24'h00_0000, irq_mask_reg};
            `ADDR_RAIL_STATE: rdata_next = {28'h000_0000, switch_rail_b_en,
                                            switch_rail_a_en, termination_reg_en,
                                            linear_reg_a3_en};
            default:          addr_ok = 1'b0;
        endcase
    end

    // Reserved bits 7 and 2 are plain storage, all bits writable
    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            override_reg   <= OVERRIDE_RESET;
            gpo_reg        <= `RST_GPO;
            fault_mask_reg <= `RST_FAULT_MASK;
            irq_mask_reg   <= `RST_IRQ_MASK;
        end else if (clk_en && wr_fire && pstrb[0]) begin
            case (paddr)
                `ADDR_OVERRIDE:   override_reg   <= pwdata[7:0];
                `ADDR_GPO:        gpo_reg        <= pwdata[7:0];
                `ADDR_FAULT_MASK: fault_mask_reg <= pwdata[7:0];
                `ADDR_IRQ_MASK:   irq_mask_reg   <= pwdata[7:0];
                default:          ;
            endcase
        end
    end

    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_ok;
            if (rd_fire) begin
                prdata <= rdata_next;
            end
        end
    end

    assign switch_rail_b_kill_n     = override_reg[`BIT_SWB_KILL_N];
    assign switch_rail_a_kill_n     = override_reg[`BIT_SWA_KILL_N];
    assign termination_reg_kill_n   = override_reg[`BIT_TERM_KILL_N];
    assign termination_reg_force_on = override_reg[`BIT_TERM_FORCE];
    assign switch_rail_b_force_on   = override_reg[`BIT_SWB_FORCE];
    assign linear_reg_a3_force_on   = override_reg[`BIT_LA3_FORCE];
    assign open_drain_out_level     = gpo_reg[`BIT_GPO_LEVEL];

    // Kill wins over force and over the sequencer
    assign en_b = switch_rail_b_kill_n & (switch_rail_b_force_on | seq_switch_b_en);
    assign en_a = switch_rail_a_kill_n & seq_switch_a_en;
    assign en_t = termination_reg_kill_n & (termination_reg_force_on | seq_term_en);
    assign en_l = linear_reg_a3_force_on | shared_linear_enable_pin;

    // Bit order: A2, switch A, step-down 6..1
    assign fault_hit = rail_fault & ~fault_mask_reg;

    // Write-one-to-clear, a new event in the same cycle wins
    assign clr_bits = (wr_fire && pstrb[0] && paddr == `ADDR_IRQ_STATUS) ?
                      pwdata[7:0] : 8'h00;

    always @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            irq_status_reg     <= 8'h00;
            switch_rail_b_en   <= 1'b0;
            switch_rail_a_en   <= 1'b0;
            termination_reg_en <= 1'b0;
            linear_reg_a3_en   <= 1'b0;
            shutdown_req       <= 1'b0;
            open_drain_out_o   <= 1'b0;
            open_drain_out_oe  <= 1'b0;
            irq                <= 1'b0;
        end else if (clk_en) begin
            irq_status_reg     <= (irq_status_reg & ~clr_bits) | fault_hit;
            switch_rail_b_en   <= en_b;
            switch_rail_a_en   <= en_a;
            termination_reg_en <= en_t;
            linear_reg_a3_en   <= en_l;
            shutdown_req       <= |fault_hit;
            open_drain_out_o   <= 1'b0;
            open_drain_out_oe  <= ~open_drain_out_level;
            irq                <= |(irq_status_reg & irq_mask_reg);
        end
    end
endmodule // rail_override_fault_mask_regs

// ### verif/rail_regs_checker.sv
`timescale 1ns/1ps
module rail_regs_checker (
    input        clk,
    input        rst_n,
    input        psel,
    input        penable,
    input        pwrite,
    input [11:0] paddr,
    input [31:0] pwdata,
    input        pready,
    input        pslverr,
    input        switch_rail_b_en,
    input        switch_rail_a_en,
    input        shutdown_req,
    input        open_drain_out_o,
    input [7:0]  rail_fault
);
    wire acc = psel && penable && !pready;
    wire wr  = acc && pwrite && paddr == 12'h27c;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_WAIT: assert property (acc |=> pready) else $error("late");
    AST_PULSE: assert property (pready |=> !pready) else $error("pulse");
    AST_ERR: assert property (pslverr |-> pready) else $error("err");
    // Wait state, register update, then one cycle of enable lag
    AST_KILL_B: assert property (wr && !pwdata[6] |-> ##3 !switch_rail_b_en)
        else $error("kill b");
    AST_KILL_A: assert property (wr && !pwdata[5] |-> ##3 !switch_rail_a_en)
        else $error("kill a");
    AST_FORCE_B: assert property (wr && pwdata[6] && pwdata[1] |-> ##3 switch_rail_b_en)
        else $error("force b");
    AST_SHUT: assert property (rail_fault == 8'h00 |=> !shutdown_req)
        else $error("shut");
    AST_OD: assert property (!open_drain_out_o) else $error("od");
endmodule // rail_regs_checker

bind rail_override_fault_mask_regs rail_regs_checker u_rail_regs_checker (.*);

// ### verif/rail_override_fault_mask_regs_tb_top.sv
`timescale 1ns/1ps
`include "rail_override_defs.vh"
module rail_override_fault_mask_regs_tb_top;
    reg         clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
    reg  [11:0] paddr = 0;
    reg  [31:0] pwdata = 0, rd;
    reg  [3:0]  seq = 0;
    reg  [7:0]  rail_fault = 0;
    wire [31:0] prdata;
    wire        pready, pslverr, switch_rail_b_en, switch_rail_a_en, termination_reg_en;
    wire        linear_reg_a3_en, shutdown_req, open_drain_out_o, open_drain_out_oe, irq;
    wire [3:0]  rails = {switch_rail_b_en, switch_rail_a_en, termination_reg_en, linear_reg_a3_en};
    integer     n_mismatch = 0, compares = 0;
    rail_override_fault_mask_regs u_rail_override_fault_mask_regs (.*, .clk_en(1'b1),
        .pstrb(4'h1), .seq_switch_b_en(seq[3]), .seq_switch_a_en(seq[2]),
        .seq_term_en(seq[1]), .shared_linear_enable_pin(seq[0]));
    initial forever #5 clk = ~clk;
    task chk(input [63:0] n, input [31:0] e, input [31:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %0s exp %h got %h", n, e, g);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1;
            @(posedge clk);
            while (pready !== 1'b1)
                @(posedge clk);
            rd = prdata;
            er = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    task rdc(input [11:0] a, input [31:0] e);
        begin
            apb(0, a, 32'h0000_0000);
            chk("prdata", e, rd);
        end
    endtask
    task ovr(input [3:0] s, input [7:0] v, input [3:0] e);
        begin
            seq <= s;
            apb(1, `ADDR_OVERRIDE, {24'h00_0000, v});
            rdc(`ADDR_OVERRIDE, {24'h00_0000, v});
            chk("rails", e, rails);
        end
    endtask
    task end_of_test;
        begin
            $display("compares %0d n_mismatch %0d", compares, n_mismatch);
            if (n_mismatch == 0 && compares > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        #20000;
        n_mismatch = n_mismatch + 1;
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        rdc(`ADDR_OVERRIDE, 32'h0000_0070);
        rdc(`ADDR_GPO, 32'h0000_0020);
        rdc(`ADDR_FAULT_MASK, 32'h0000_00c0);
        $display("reset test done");
        ovr(4'hf, 8'h84, 4'h1);
        ovr(4'h0, 8'h2a, 4'h0);
        ovr(4'h0, 8'h7b, 4'hb);
        ovr(4'he, 8'h70, 4'he);
        $display("override test done");
        apb(1, `ADDR_GPO, 32'h0000_0000);
        rdc(`ADDR_GPO, 32'h0000_0000);
        chk("od", 1, {open_drain_out_o, open_drain_out_oe});
        apb(1, `ADDR_GPO, 32'h0000_0020);
        rdc(`ADDR_GPO, 32'h0000_0020);
        chk("od", 0, {open_drain_out_o, open_drain_out_oe});
        rail_fault <= 8'h81;
        rdc(`ADDR_IRQ_STATUS, 32'h0000_0001);
        chk("fault", 2, {shutdown_req, irq});
        apb(1, `ADDR_IRQ_MASK, 32'h0000_0001);
        rdc(`ADDR_IRQ_MASK, 32'h0000_0001);
        chk("fault", 3, {shutdown_req, irq});
        apb(1, `ADDR_FAULT_MASK, 32'h0000_00c1);
        apb(1, `ADDR_IRQ_STATUS, 32'h0000_00ff);
        rdc(`ADDR_FAULT_MASK, 32'h0000_00c1);
        chk("fault", 0, {shutdown_req, irq});
        apb(1, `ADDR_UNMAPPED, 32'h0000_00ff);
        chk("slverr", 1, er);
        $display("fault test done");
        end_of_test;
    end
endmodule // rail_override_fault_mask_regs_tb_top
